// ===== fsp_pkg.sv
// Package for the flash status poller: register map, pin groups, states and timing
package fsp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] ADDR_OFS   = 8'h04;
  localparam logic [7:0] WDATA_OFS  = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] RDATA_OFS  = 8'h10;
  localparam logic [7:0] TIMER_OFS  = 8'h14;

  // CTRL command codes (written into CTRL bits 2:0)
  localparam logic [2:0] CMD_NONE   = 3'h0;
  localparam logic [2:0] CMD_WRITE  = 3'h1;
  localparam logic [2:0] CMD_READ   = 3'h2;
  localparam logic [2:0] CMD_POLL   = 3'h3;
  localparam logic [2:0] CMD_TIMER  = 3'h4;
  localparam logic [2:0] CMD_RESET  = 3'h5;
  localparam int         CMD_W      = 3;

  // Data bus bit positions of the status bits
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int FAIL_BIT   = 5;
  localparam int TIMER_BIT  = 3;
  localparam int SECTOR_BIT = 2;

  // STATUS register fields
  localparam int ST_BUSY  = 0;
  localparam int ST_DONE  = 1;
  localparam int ST_FAIL  = 2;
  localparam int ST_RYBY  = 3;
  localparam int ST_TIMER = 4;

  // Reset command datum for the flash
  localparam logic [15:0] RESET_DATA = 16'h00F0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 100;
  localparam int STROBE_NS    = 80;
  localparam int STROBE_CYC   = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W        = 4;
  localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYC);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        sel_n;
    logic        oe_n;
    logic        we_n;
    logic [21:0] addr;
    logic [15:0] dq_o;
    logic        dq_oe;
  } flash_pins_s;

  typedef enum logic [3:0] {
    S_IDLE   = 4'b0000,
    S_WR     = 4'b0001,
    S_WRHI   = 4'b0010,
    S_RD     = 4'b0011,
    S_RDHI   = 4'b0100,
    S_POLL1  = 4'b0101,
    S_POLL2  = 4'b0110,
    S_CHECK  = 4'b0111,
    S_RSTCMD = 4'b1000
  } seq_e;

endpackage

// ===== fsp_strobe.sv
// One strobed flash bus cycle timer
`timescale 1ns/1ns
module fsp_strobe (
  input  wire logic CLK_SYS_IN,
  input  wire logic SRST_IN,
  input  wire logic start_in,
  output logic      active_out,
  output logic      done_out
);
  import fsp_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             act_q;
  logic             act_d;

  // Count the low phase of the strobe
  always_comb begin
    cnt_d = cnt_q;
    act_d = act_q;
    if (start_in && !act_q) begin
      act_d = 1'b1;
      cnt_d = STROBE_CNT;
    end else if (act_q) begin
      if (cnt_q == '0) begin
        act_d = 1'b0;
      end else begin
        cnt_d = cnt_q - CNT_W'(1);
      end
    end
  end

  // Registered state
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      cnt_q <= '0;
      act_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      act_q <= act_d;
    end
  end

  assign active_out = act_q;
  assign done_out   = act_q && (cnt_q == '0);

endmodule

// ===== fsp_ahb.sv
// AHB-Lite slave front end: single word transfers, zero wait states
`timescale 1ns/1ns
module fsp_ahb (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        SRST_IN,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic        hready_in,
  output logic             wr_out,
  output logic             rd_out,
  output logic [7:0]       addr_out
);
  import fsp_pkg::*;

  logic       wr_q;
  logic       wr_d;
  logic [7:0] a_q;
  logic [7:0] a_d;
  logic       take;

  // Capture address phase; the write lands in the data phase
  always_comb begin
    take = hsel_in && htrans_in[1] && hready_in;
    wr_d = take && hwrite_in;
    a_d  = take ? haddr_in[7:0] : a_q;
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      wr_q <= 1'b0;
      a_q  <= 8'h00;
    end else begin
      wr_q <= wr_d;
      a_q  <= a_d;
    end
  end

  assign wr_out   = wr_q;
  assign rd_out   = take && !hwrite_in;
  assign addr_out = take ? haddr_in[7:0] : a_q;

endmodule

// ===== fsp_top.sv
// Host-side flash status poller: issues cycles and runs the toggle polling procedure
`timescale 1ns/1ns
module fsp_top (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        SRST_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic        HREADY_IN,
  input  wire logic [31:0] HWDATA_IN,
  output logic [31:0]      HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  input  wire logic [15:0] DQ_IN,
  input  wire logic        READY_BUSY_N_IN,
  output fsp_pkg::flash_pins_s FLASH_OUT
);
  import fsp_pkg::*;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic       bus_wr;
  logic       bus_rd;
  logic [7:0] bus_addr;

  fsp_ahb u_ahb (
    .CLK_SYS_IN (CLK_SYS_IN),
    .SRST_IN    (SRST_IN),
    .hsel_in    (HSEL_IN),
    .haddr_in   (HADDR_IN),
    .htrans_in  (HTRANS_IN),
    .hwrite_in  (HWRITE_IN),
    .hready_in  (HREADY_IN),
    .wr_out     (bus_wr),
    .rd_out     (bus_rd),
    .addr_out   (bus_addr)
  );

  // ----------------------------------------------------------------
  // Strobe timer
  // ----------------------------------------------------------------
  logic stb_start;
  logic stb_act;
  logic stb_done;

  fsp_strobe u_stb (
    .CLK_SYS_IN (CLK_SYS_IN),
    .SRST_IN    (SRST_IN),
    .start_in   (stb_start),
    .active_out (stb_act),
    .done_out   (stb_done)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  seq_e        st_q, st_d;
  logic [21:0] addr_q, addr_d;
  logic [15:0] wdat_q, wdat_d;
  logic [15:0] rdat_q, rdat_d;
  logic [15:0] prev_q, prev_d;
  logic        busy_q, busy_d;
  logic        done_q, done_d;
  logic        fail_q, fail_d;
  logic        tmr_q, tmr_d;
  logic        fchk_q, fchk_d;
  logic        ryby_q;
  logic [31:0] hrd_q, hrd_d;
  logic        go;
  logic [CMD_W-1:0] cmd;
  logic        toggled;

  assign go      = bus_wr && (bus_addr == CTRL_OFS) && !busy_q;
  assign cmd     = HWDATA_IN[CMD_W-1:0];
  // A changed toggle bit means the device still runs its algorithm
  assign toggled = DQ_IN[TOGGLE_BIT] != prev_q[TOGGLE_BIT];

  // Sequencer next state
  always_comb begin
    st_d      = st_q;
    addr_d    = addr_q;
    wdat_d    = wdat_q;
    rdat_d    = rdat_q;
    prev_d    = prev_q;
    busy_d    = busy_q;
    done_d    = done_q;
    fail_d    = fail_q;
    tmr_d     = tmr_q;
    fchk_d    = fchk_q;
    stb_start = 1'b0;
    if (bus_wr && bus_addr == ADDR_OFS && !busy_q) begin
      addr_d = HWDATA_IN[21:0];
    end
    if (bus_wr && bus_addr == WDATA_OFS && !busy_q) begin
      wdat_d = HWDATA_IN[15:0];
    end
    unique case (st_q)
      S_IDLE: begin
        if (go) begin
          busy_d = 1'b1;
          done_d = 1'b0;
          unique case (cmd)
            CMD_WRITE: st_d = S_WR;
            CMD_READ:  st_d = S_RD;
            CMD_TIMER: st_d = S_RD; // Optional when sector commands come fast
            // Every poll starts from the first read again
            CMD_POLL: begin
              st_d   = S_POLL1;
              fail_d = 1'b0;
              fchk_d = 1'b0;
            end
            CMD_RESET: begin
              st_d   = S_RSTCMD;
              wdat_d = RESET_DATA;
            end
            default: begin
              busy_d = 1'b0;
              done_d = 1'b1;
            end
          endcase
          tmr_d = (cmd == CMD_TIMER);
        end
      end
      S_WR, S_RSTCMD: begin
        stb_start = 1'b1;
        if (stb_done) begin
          st_d = S_WRHI;
        end
      end
      S_WRHI: begin
        st_d   = S_IDLE;
        busy_d = 1'b0;
        done_d = 1'b1;
      end
      S_RD: begin
        stb_start = 1'b1;
        if (stb_done) begin
          rdat_d = DQ_IN;
          st_d   = S_RDHI;
        end
      end
      S_RDHI: begin
        st_d   = S_IDLE;
        busy_d = 1'b0;
        done_d = 1'b1;
      end
      S_POLL1: begin
        stb_start = 1'b1;
        if (stb_done) begin
          prev_d = DQ_IN;
          st_d   = S_CHECK;
        end
      end
      S_CHECK: begin
        st_d = S_POLL2; // one idle cycle closes the read strobe
      end
      S_POLL2: begin
        stb_start = 1'b1;
        if (stb_done) begin
          rdat_d = DQ_IN;
          prev_d = DQ_IN;
          if (!toggled) begin
            st_d   = S_RDHI;
          end else if (fchk_q) begin
            fail_d = 1'b1;
            st_d   = S_RDHI;
          end else if (DQ_IN[FAIL_BIT]) begin
            fchk_d = 1'b1;
            st_d   = S_CHECK;
          end else begin
            st_d = S_CHECK;
          end
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      st_q   <= S_IDLE;
      addr_q <= '0;
      wdat_q <= '0;
      rdat_q <= '0;
      prev_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      tmr_q  <= 1'b0;
      fchk_q <= 1'b0;
      ryby_q <= 1'b1;
    end else begin
      st_q   <= st_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      prev_q <= prev_d;
      busy_q <= busy_d;
      done_q <= done_d;
      fail_q <= fail_d;
      tmr_q  <= tmr_d;
      fchk_q <= fchk_d;
      ryby_q <= READY_BUSY_N_IN;
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // Status reads go to the address software loaded, inside the busy bank
  logic wr_cyc;
  assign wr_cyc = (st_q == S_WR) || (st_q == S_RSTCMD);

  always_comb begin
    FLASH_OUT       = '0;
    FLASH_OUT.addr  = addr_q;
    FLASH_OUT.dq_o  = wdat_q;
    FLASH_OUT.sel_n = !stb_act;
    FLASH_OUT.we_n  = !(stb_act && wr_cyc);
    // The state term keeps oe_n from glitching low as a write strobe ends
    FLASH_OUT.oe_n  = !(stb_act && !wr_cyc && (st_q != S_WRHI));
    FLASH_OUT.dq_oe = wr_cyc;
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Timer check result lives in STATUS so software can compare before and after
  always_comb begin
    hrd_d = 32'h0000_0000;
    if (bus_rd) begin
      unique case (bus_addr)
        CTRL_OFS:   hrd_d = {29'h0, st_q[2:0]};
        ADDR_OFS:   hrd_d = {10'h0, addr_q};
        WDATA_OFS:  hrd_d = {16'h0, wdat_q};
        STATUS_OFS: begin
          hrd_d[ST_BUSY]  = busy_q;
          hrd_d[ST_DONE]  = done_q;
          hrd_d[ST_FAIL]  = fail_q;
          hrd_d[ST_RYBY]  = ryby_q;
          hrd_d[ST_TIMER] = tmr_q && rdat_q[TIMER_BIT];
        end
        RDATA_OFS:  hrd_d = {16'h0, rdat_q};
        default:    hrd_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      hrd_q <= '0;
    end else begin
      hrd_q <= hrd_d;
    end
  end

  assign HRDATA_OUT    = hrd_q;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = 1'b0;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence poll_second_read;
    (st_q == S_POLL2) && stb_done;
  endsequence

  stable_done_a: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    poll_second_read and !toggled |=> st_q == S_RDHI ##1 done_q && !fail_q)
    else $error("poll did not finish on stable toggle bit");

  fail_after_recheck_a: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    poll_second_read and toggled && fchk_q |=> ##1 fail_q)
    else $error("fail not flagged after recheck");

  recheck_on_fail_a: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    poll_second_read and toggled && !fchk_q && DQ_IN[FAIL_BIT] |=> fchk_q && st_q == S_CHECK)
    else $error("no recheck after fail bit");

  poll_restart_a: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    st_q == S_IDLE && go && cmd == CMD_POLL |=> st_q == S_POLL1 && !fchk_q && !fail_q)
    else $error("poll did not restart from first read");

  reset_data_a: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    st_q == S_RSTCMD && !FLASH_OUT.we_n |-> FLASH_OUT.dq_o == RESET_DATA && FLASH_OUT.dq_oe)
    else $error("reset command datum wrong");

  strobe_exclusive_a: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    !(FLASH_OUT.we_n || FLASH_OUT.oe_n) |-> 1'b0)
    else $error("write and read strobes together");

  read_gap_a: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    poll_second_read |=> FLASH_OUT.oe_n)
    else $error("read strobe not released between polls");

  write_rise_a: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    $rose(FLASH_OUT.we_n) && st_q == S_WRHI |=> done_q && !busy_q)
    else $error("write end not reported");

endmodule

// ===== flash_dev_model.sv
// Behavioural flash device that answers the poller's strobed reads with status words while busy, else with array data
`timescale 1ns/1ns
module flash_dev_model (
  input  fsp_pkg::flash_pins_s pins_in,
  output logic [15:0]          dq_out,
  output logic                 ready_busy_n_out
);
  import fsp_pkg::*;

  // ----------------------------------------------------------------
  // Device state
  // ----------------------------------------------------------------
  logic        busy_q   = 1'b0;     // Embedded algorithm running
  logic        fail_q   = 1'b0;     // Pulse count limit exceeded
  logic        timer_q  = 1'b0;     // Sector erase window has closed
  logic        toggle_q = 1'b0;
  logic        erase_q  = 1'b0;     // Running algorithm is a sector erase
  logic        wr_seen  = 1'b0;     // A write strobe has really gone low
  // Erase never clears this word, as if its sector were protected and skipped
  logic [15:0] mem_q    = 16'hFFFF; // One array word is enough for this bench
  logic [15:0] last_q   = 16'h0000;
  int          left_q   = 0;
  logic        rd_act;
  logic        wr_act;
  logic [15:0] stat_w;
  logic        poll_bit;

  // A cycle counts only while the chip is selected and its strobe is low
  assign rd_act = !pins_in.sel_n && !pins_in.oe_n;
  assign wr_act = !pins_in.sel_n && !pins_in.we_n;

  // Status word: inverted data bit, toggle, fail and erase timer bits
  // Polling bit reads zero during erase, else the inverse of the written bit
  assign poll_bit = erase_q ? 1'b0 : ~mem_q[7];
  assign stat_w   = {8'h00, poll_bit, toggle_q, fail_q, 1'b0, timer_q, erase_q & toggle_q, 2'b00};
  // Released bus shows the inverse of the last word so a stale sample never matches
  assign dq_out = rd_act ? (busy_q ? stat_w : mem_q) : ~last_q;
  // Open-drain pin low only while the algorithm runs
  assign ready_busy_n_out = !busy_q;

  // Starts an operation that ends after a number of status reads; a failing one ends only on the reset datum
  // Read count stands in for the timed toggle spans of protected targets
  // Non-blocking, so the pin changes after the edge at which the bench calls this
  task automatic begin_op(input int reads, input logic fail, input logic timer);
    busy_q  <= 1'b1;
    left_q  <= reads;
    fail_q  <= fail;
    timer_q <= timer;
    erase_q <= timer;
  endtask

  // End of each read cycle advances the toggle bit while busy
  always @(negedge rd_act) begin
    last_q = busy_q ? stat_w : mem_q;
    if (busy_q) begin
      toggle_q = ~toggle_q;
      if (!fail_q) begin
        left_q = left_q - 1;
        if (left_q <= 0) busy_q = 1'b0;
      end
    end
  end

  // Reset datum ends a failed operation; any other word is stored
  // Power-up unknowns settling low are not a write cycle
  always @(posedge wr_act) begin
    wr_seen = 1'b1;
  end

  always @(negedge wr_act) begin
    if (wr_seen) begin
      if (pins_in.dq_o == RESET_DATA) begin
        busy_q = 1'b0;
        fail_q = 1'b0;
      end else begin
        mem_q = pins_in.dq_o;
      end
    end
    wr_seen = 1'b0;
  end
endmodule

// ===== tb_flash_write_status_reporting.sv
// Self-checking bench: poller driven over AHB-Lite against a behavioural flash
`timescale 1ns/1ns
module tb_flash_write_status_reporting;
  import fsp_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk;
  logic        srst   = 1'b1;
  logic        hsel   = 1'b0;
  logic [31:0] haddr  = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [15:0] dq_mdl;
  logic [15:0] dq_bus;
  logic        ryby_n;
  flash_pins_s pins;
  logic [31:0] s;
  int          n_mismatch = 0;
  int          checked    = 0;

  // One slave, so its ready is the bus ready
  fsp_top uut (
    .CLK_SYS_IN      (clk),
    .SRST_IN         (srst),
    .HSEL_IN         (hsel),
    .HADDR_IN        (haddr),
    .HTRANS_IN       (htrans),
    .HWRITE_IN       (hwrite),
    .HSIZE_IN        (3'b010),
    .HREADY_IN       (hreadyout),
    .HWDATA_IN       (hwdata),
    .HRDATA_OUT      (hrdata),
    .HREADYOUT_OUT   (hreadyout),
    .HRESP_OUT       (hresp),
    .DQ_IN           (dq_bus),
    .READY_BUSY_N_IN (ryby_n),
    .FLASH_OUT       (pins)
  );

  flash_dev_model mdl (
    .pins_in          (pins),
    .dq_out           (dq_mdl),
    .ready_busy_n_out (ryby_n)
  );

  // Data wire level: the poller wins while it drives, else the device
  assign dq_bus = pins.dq_oe ? pins.dq_o : dq_mdl;

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------
  task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= 1'b1;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask

  task automatic ahb_rd(input logic [7:0] a, output logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= 1'b0;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    do @(posedge clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    checked++;
    if ((got & m) !== (exp & m)) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got & m, exp & m);
    end
  endtask

  // Issue a command and wait until the poller reports idle; the watchdog bounds a hang
  task automatic run_cmd(input logic [2:0] c);
    logic [31:0] st;
    ahb_wr(CTRL_OFS, {29'h0, c});
    do ahb_rd(STATUS_OFS, st); while (st[ST_BUSY] !== 1'b0);
  endtask

  task automatic end_of_test;
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    ahb_rd(STATUS_OFS, s);
    cmp(s, 32'h0000_0008, 32'h0000_001F);
    ahb_rd(TIMER_OFS, s);
    cmp(s, 32'h0000_0000, 32'hFFFF_FFFF);
    cmp({31'h0, hresp}, 32'h0000_0000, 32'h0000_0001);
    // Plain program and read back with the device idle
    ahb_wr(ADDR_OFS, 32'h0000_0123);
    ahb_wr(WDATA_OFS, 32'h0000_5A5A);
    run_cmd(CMD_WRITE);
    run_cmd(CMD_READ);
    ahb_rd(RDATA_OFS, s);
    cmp(s, 32'h0000_5A5A, 32'h0000_FFFF);
    // Short program: busy pin low, toggling stops after six reads
    mdl.begin_op(6, 1'b0, 1'b0);
    @(posedge clk); // Let the busy pin reach the poller's status flop
    ahb_rd(STATUS_OFS, s);
    cmp(s, 32'h0000_0000, 32'h0000_0008);
    run_cmd(CMD_POLL);
    ahb_rd(STATUS_OFS, s);
    cmp(s, 32'h0000_000A, 32'h0000_000F);
    // Erase with the acceptance window closed: timer bit reads one
    mdl.begin_op(400, 1'b0, 1'b1);
    run_cmd(CMD_TIMER);
    ahb_rd(STATUS_OFS, s);
    cmp(s, 32'h0000_0010, 32'h0000_0019);
    // Long poll; an address write meanwhile must not reach the pins
    ahb_wr(CTRL_OFS, {29'h0, CMD_POLL});
    ahb_wr(ADDR_OFS, 32'h0000_03FF);
    repeat (20) @(posedge clk);
    cmp({10'h0, pins.addr}, 32'h0000_0123, 32'hFFFF_FFFF);
    do ahb_rd(STATUS_OFS, s); while (s[ST_BUSY] !== 1'b0);
    cmp(s, 32'h0000_000A, 32'h0000_000F);
    // Toggling never stops and the fail bit is set
    mdl.begin_op(1, 1'b1, 1'b0);
    run_cmd(CMD_POLL);
    ahb_rd(STATUS_OFS, s);
    cmp(s, 32'h0000_0004, 32'h0000_000D);
    run_cmd(CMD_RESET);
    ahb_rd(STATUS_OFS, s);
    cmp(s, 32'h0000_0008, 32'h0000_0008);
    // Fresh poll after recovery starts from the first read
    run_cmd(CMD_POLL);
    ahb_rd(STATUS_OFS, s);
    cmp(s, 32'h0000_0002, 32'h0000_0006);
    end_of_test;
  end

  // Watchdog: the scenarios need about 5k cycles
  initial begin
    #500000;
    n_mismatch++;
    end_of_test;
  end
endmodule
